/* File: src/mmp_pkg.sv */
// memory map and nonvolatile access policy: shared constants and types
// assumes a single system clock domain; all users refer to names as mmp_pkg::name
package mmp_pkg;

  // ==========================================
  // data space map
  localparam logic [19:0] IO_LIMIT = 20'h01000;
  localparam logic [19:0] EEP_BASE = 20'h01000;
  localparam logic [19:0] EEP_SIZE = 20'h00800;
  localparam logic [19:0] EEP_END = EEP_BASE + EEP_SIZE;
  localparam logic [19:0] SRAM_BASE = 20'h02000;
  localparam logic [19:0] SRAM_SIZE = 20'h02000;
  localparam logic [19:0] SRAM_END = SRAM_BASE + SRAM_SIZE;
  localparam logic [19:0] DATA_TOP = 20'hFFFFF;

  // ==========================================
  // direct io space
  localparam logic [5:0] GP_LIMIT = 6'h10;
  localparam logic [5:0] BIT_IO_LAST = 6'h1F;
  localparam int GP_COUNT = 16;

  // ==========================================
  // flash layout, word addressed
  localparam int FW_W = 16;
  localparam logic [16:0] BOOT_WORDS = 17'h01000;
  localparam logic [16:0] APP_WORDS = 17'h10000;
  localparam logic [16:0] BOOT_BASE = APP_WORDS;
  localparam logic [16:0] TBL_BASE = APP_WORDS - BOOT_WORDS;

  // ==========================================
  // lock and fuse bytes, one means unprogrammed
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] FUSE_RST = 8'hFF;
  localparam int LCK_W = 0;
  localparam int LCK_R = 1;
  localparam int LCK_APP = 0;
  localparam int LCK_TBL = 2;
  localparam int LCK_BOOT = 4;

  // ==========================================
  // types
  typedef enum logic [2:0] {SP_FLASH, SP_USIG, SP_PSIG, SP_FUSE, SP_LOCK} mmp_space_type;
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_ERASE, CMD_CHIP} mmp_cmd_type;
  typedef enum logic [1:0] {BIT_SET, BIT_CLR, BIT_TEST} mmp_bitop_type;
  typedef enum logic [1:0] {SEC_APP, SEC_TBL, SEC_BOOT} mmp_sec_type;

  typedef struct packed {
    logic prog;
    mmp_cmd_type cmd;
    mmp_space_type space;
    logic [16:0] addr;
    logic [16:0] pc;
    logic [FW_W-1:0] data;
  } mmp_req_type;

  typedef struct packed {
    mmp_space_type space;
    logic [16:0] addr;
    logic [FW_W-1:0] data;
  } mmp_op_type;

  typedef struct packed {
    logic io;
    logic gp;
    logic eep;
    logic sram;
    logic ext;
  } mmp_dsel_type;

endpackage

/* File: src/mmp_gpreg.sv */
// general purpose io byte store with per-bit set and clear
// assumes one access per cycle; read data is registered
`timescale 1ns/10ps
module mmp_gpreg (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // access
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] set_mask,
  input wire logic [7:0] clr_mask,
  output logic [7:0] rdata
);

  logic [7:0] mem_q [mmp_pkg::GP_COUNT];

  // ==========================================
  // storage
  for (genvar i = 0; i < mmp_pkg::GP_COUNT; i++) begin : g_ent
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_q[i] <= 8'h00;
      end else if (addr == 4'(i)) begin
        if (we) begin
          mem_q[i] <= wdata;
        end else begin
          mem_q[i] <= (mem_q[i] & ~clr_mask) | set_mask;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[addr];
    end
  end

endmodule // mmp_gpreg

/* File: src/mmp_policy.sv */
// data space decoder and nonvolatile access policy
// assumes core and programmer requests are synchronous to sys_clk and one per cycle
//
// Operation
// (RULE1) flash self-write instruction programs only when fetched from boot section
// (RULE2) from boot section it may target any flash word, boot included
// (RULE3) flash location is one 16-bit word; instructions take one or two
// (RULE4) application table region is as large as boot section
// (RULE5) application, table and boot sections have independent lock fields
// (RULE6) lock writes only make protection stricter; relaxing is ignored
// (RULE7) only chip erase clears locks, after all other flash is erased; sys_rst also reloads lock_q with LOCK_RST
// (RULE8) unprogrammed fuse or lock bit reads one, programmed reads zero
// (RULE9) fuses written only by programmer; core may read, core writes ignored
// (RULE10) production signature row rejects write and erase, stays readable
// (RULE11) reset copies one calibration value; the rest left to software
// (RULE12) user signature row read/write by both; chip erase leaves it
// (RULE13) internal sram starts at data address 0x2000
// (RULE14) eeprom mapped at 0x1000 only when mapping is selected
// (RULE15) external memory from end of sram up to 0xFFFFF
// (RULE16) direct io reaches 0x00 to 0x3F; all io reachable by load/store
// (RULE17) io 0x00 to 0x1F allow single-cycle bit set, clear, test
// (RULE18) flash reachable by programmer port and by core software
// (RULE19) lowest 16 io bytes are bit-addressable storage
// (RULE20) lock change applies to every check after the lock write
`timescale 1ns/10ps
module mmp_policy (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // data space access
  input wire logic [19:0] dat_addr,
  input wire logic dat_we,
  input wire logic [7:0] dat_wdata,
  input wire logic eep_map_en,
  output mmp_pkg::mmp_dsel_type dat_sel,
  output logic [7:0] gp_rdata,
  // direct io bit access
  input wire logic io_bit_req,
  input mmp_pkg::mmp_bitop_type io_bit_op,
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  output logic io_bit_fwd,
  output logic io_bit_err,
  output logic io_bit_vld,
  output logic io_bit_val,
  // nonvolatile requests
  input wire logic nvm_valid,
  input mmp_pkg::mmp_req_type nvm_req,
  output logic nvm_busy,
  output logic nvm_ok,
  output logic nvm_deny,
  // flash array strobes
  output logic arr_rd,
  output logic arr_wr,
  output logic arr_erase,
  output logic arr_erase_all,
  output mmp_pkg::mmp_op_type arr_op,
  input wire logic arr_done,
  // lock, fuse and calibration
  output logic [7:0] lock_bits,
  output logic [7:0] fuse_bits,
  input wire logic [7:0] psig_cal,
  output logic cal_load,
  output logic [7:0] cal_value
);

  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_ERASE, ST_UNLOCK} mmp_state_type;

  mmp_state_type state_q, state_d;
  logic [7:0] lock_q, lock_d, fuse_q, fuse_d;
  logic [2:0] bit_q;
  logic test_q;

  // ==========================================
  // data space decode
  assign dat_sel.io = dat_addr < mmp_pkg::IO_LIMIT; // [RULE16]
  assign dat_sel.gp = dat_addr < 20'(mmp_pkg::GP_LIMIT); // [RULE19]
  assign dat_sel.eep = eep_map_en && dat_addr >= mmp_pkg::EEP_BASE
                       && dat_addr < mmp_pkg::EEP_END; // [RULE14]
  assign dat_sel.sram = dat_addr >= mmp_pkg::SRAM_BASE && dat_addr < mmp_pkg::SRAM_END; // [RULE13]
  assign dat_sel.ext = dat_addr >= mmp_pkg::SRAM_END && dat_addr <= mmp_pkg::DATA_TOP; // [RULE15]

  // ==========================================
  // io bit operations
  logic bit_ok, bit_gp, gp_we;
  logic [7:0] bit_mask, set_mask, clr_mask;
  logic [3:0] gp_addr;

  assign bit_ok = io_bit_req && io_addr <= mmp_pkg::BIT_IO_LAST; // [RULE17]
  assign bit_gp = bit_ok && io_addr < mmp_pkg::GP_LIMIT; // [RULE19]
  assign io_bit_fwd = bit_ok && !bit_gp;
  assign io_bit_err = io_bit_req && !bit_ok;
  assign bit_mask = 8'(8'h01 << io_bit);
  assign set_mask = (bit_gp && io_bit_op == mmp_pkg::BIT_SET) ? bit_mask : 8'h00; // [RULE17]
  assign clr_mask = (bit_gp && io_bit_op == mmp_pkg::BIT_CLR) ? bit_mask : 8'h00; // [RULE17]
  assign gp_we = !io_bit_req && dat_we && dat_sel.gp; // [RULE16]
  assign gp_addr = io_bit_req ? io_addr[3:0] : dat_addr[3:0];
  assign io_bit_vld = test_q;
  assign io_bit_val = test_q && gp_rdata[bit_q];

  mmp_gpreg u_gpreg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .we(gp_we),
    .addr(gp_addr),
    .wdata(dat_wdata),
    .set_mask(set_mask),
    .clr_mask(clr_mask),
    .rdata(gp_rdata)
  );

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_q <= 1'b0;
      bit_q <= 3'h0;
    end else begin
      test_q <= bit_gp && io_bit_op == mmp_pkg::BIT_TEST;
      bit_q <= io_bit;
    end
  end

  // ==========================================
  // flash sections and locks
  function automatic mmp_pkg::mmp_sec_type sec_of(input logic [16:0] a);
    if (a >= mmp_pkg::BOOT_BASE) begin
      return mmp_pkg::SEC_BOOT;
    end else if (a >= mmp_pkg::TBL_BASE) begin // [RULE4]
      return mmp_pkg::SEC_TBL;
    end else begin
      return mmp_pkg::SEC_APP;
    end
  endfunction

  function automatic logic [1:0] lock_of(input logic [7:0] lk, input mmp_pkg::mmp_sec_type s);
    case (s) // [RULE5]
      mmp_pkg::SEC_BOOT: return lk[mmp_pkg::LCK_BOOT +: 2];
      mmp_pkg::SEC_TBL: return lk[mmp_pkg::LCK_TBL +: 2];
      default: return lk[mmp_pkg::LCK_APP +: 2];
    endcase
  endfunction

  logic take, allow, go, is_rd, is_wr, is_er, is_chip, arr_hit, pc_boot, flash_wr_ok;
  logic [1:0] tgt_lk;

  assign take = nvm_valid && state_q == ST_IDLE;
  assign is_rd = nvm_req.cmd == mmp_pkg::CMD_READ;
  assign is_wr = nvm_req.cmd == mmp_pkg::CMD_WRITE;
  assign is_er = nvm_req.cmd == mmp_pkg::CMD_ERASE;
  assign is_chip = nvm_req.cmd == mmp_pkg::CMD_CHIP;
  assign tgt_lk = lock_of(lock_q, sec_of(nvm_req.addr)); // [RULE20]
  assign pc_boot = sec_of(nvm_req.pc) == mmp_pkg::SEC_BOOT;
  assign flash_wr_ok = tgt_lk[mmp_pkg::LCK_W] && (nvm_req.prog || pc_boot); // [RULE1] [RULE2] [RULE8]
  assign arr_hit = nvm_req.space inside {mmp_pkg::SP_FLASH, mmp_pkg::SP_USIG, mmp_pkg::SP_PSIG};

  always_comb begin
    allow = 1'b0;
    if (is_chip) begin
      allow = nvm_req.prog;
    end else begin
      case (nvm_req.space)
        mmp_pkg::SP_FLASH: allow = is_rd ? tgt_lk[mmp_pkg::LCK_R] : flash_wr_ok; // [RULE18]
        mmp_pkg::SP_USIG: allow = 1'b1; // [RULE12]
        mmp_pkg::SP_PSIG: allow = is_rd; // [RULE10]
        mmp_pkg::SP_FUSE: allow = is_rd || (is_wr && nvm_req.prog); // [RULE9]
        mmp_pkg::SP_LOCK: allow = is_rd || is_wr;
        default: allow = 1'b0;
      endcase
    end
  end

  assign go = take && allow;
  assign nvm_busy = state_q != ST_IDLE;

  // ==========================================
  // lock, fuse and sequence state
  always_comb begin
    lock_d = lock_q;
    fuse_d = fuse_q;
    if (state_q == ST_UNLOCK) begin
      lock_d = mmp_pkg::LOCK_RST; // [RULE7]
    end else if (go && is_wr && nvm_req.space == mmp_pkg::SP_LOCK) begin
      lock_d = lock_q & nvm_req.data[7:0]; // [RULE6] [RULE8]
    end
    if (go && is_wr && nvm_req.space == mmp_pkg::SP_FUSE) begin
      fuse_d = nvm_req.data[7:0]; // [RULE9]
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CAL: state_d = ST_IDLE;
      ST_IDLE: if (go && is_chip) state_d = ST_ERASE;
      ST_ERASE: if (arr_done) state_d = ST_UNLOCK; // [RULE7]
      ST_UNLOCK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_CAL;
      lock_q <= mmp_pkg::LOCK_RST;
      fuse_q <= mmp_pkg::FUSE_RST;
    end else begin
      state_q <= state_d;
      lock_q <= lock_d;
      fuse_q <= fuse_d;
    end
  end

  assign lock_bits = lock_q;
  assign fuse_bits = fuse_q;

  // ==========================================
  // answers, array strobes and calibration
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvm_ok <= 1'b0;
      nvm_deny <= 1'b0;
      arr_rd <= 1'b0;
      arr_wr <= 1'b0;
      arr_erase <= 1'b0;
      arr_erase_all <= 1'b0;
      arr_op <= '0;
      cal_load <= 1'b0;
      cal_value <= 8'h00;
    end else begin
      nvm_ok <= (go && !is_chip) || state_q == ST_UNLOCK;
      nvm_deny <= take && !allow;
      arr_rd <= go && is_rd && arr_hit;
      arr_wr <= go && is_wr && arr_hit; // [RULE3]
      arr_erase <= go && is_er && arr_hit; // [RULE12]
      arr_erase_all <= go && is_chip; // [RULE7]
      if (take) begin
        arr_op <= {nvm_req.space, nvm_req.addr, nvm_req.data};
      end
      cal_load <= state_q == ST_CAL; // [RULE11]
      if (state_q == ST_CAL) begin
        cal_value <= psig_cal;
      end
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_core_spm_out;
    take && !nvm_req.prog && is_wr && nvm_req.space == mmp_pkg::SP_FLASH && !pc_boot;
  endsequence
  property p_spm_boot_only;
    s_core_spm_out |=> nvm_deny && !arr_wr;
  endproperty
  a_spm_boot_only: assert property (p_spm_boot_only) else $error("self-write outside boot accepted"); // [RULE1]

  property p_spm_any_target;
    take && !nvm_req.prog && is_wr && nvm_req.space == mmp_pkg::SP_FLASH && pc_boot
      && tgt_lk[mmp_pkg::LCK_W] |=> arr_wr && nvm_ok && arr_op.addr == $past(nvm_req.addr);
  endproperty
  a_spm_any_target: assert property (p_spm_any_target) else $error("boot self-write not honoured"); // [RULE2]

  property p_lock_stricter;
    state_q != ST_UNLOCK |=> (lock_q & ~$past(lock_q)) == 8'h00;
  endproperty
  a_lock_stricter: assert property (p_lock_stricter) else $error("lock bit relaxed"); // [RULE6]

  sequence s_erase_run;
    arr_erase_all ##1 (state_q == ST_ERASE && !arr_done) [*2];
  endsequence
  property p_erase_order;
    s_erase_run |-> lock_q == $past(lock_q, 2);
  endproperty
  a_erase_order: assert property (p_erase_order) else $error("locks cleared before erase done"); // [RULE7]

  property p_unlock_after_done;
    state_q == ST_ERASE && arr_done |=> ##1 lock_q == mmp_pkg::LOCK_RST && nvm_ok;
  endproperty
  a_unlock_after_done: assert property (p_unlock_after_done) else $error("locks not cleared"); // [RULE7]

  property p_fuse_core;
    take && !nvm_req.prog && nvm_req.space == mmp_pkg::SP_FUSE && is_wr |=> nvm_deny && $stable(fuse_q);
  endproperty
  a_fuse_core: assert property (p_fuse_core) else $error("core changed a fuse"); // [RULE9]

  property p_psig;
    take && nvm_req.space == mmp_pkg::SP_PSIG && (is_wr || is_er) |=> nvm_deny && !arr_wr && !arr_erase;
  endproperty
  a_psig: assert property (p_psig) else $error("production row altered"); // [RULE10]

  property p_lock_now;
    go && is_wr && nvm_req.space == mmp_pkg::SP_LOCK
      |=> lock_q == ($past(lock_q) & $past(nvm_req.data[7:0]));
  endproperty
  a_lock_now: assert property (p_lock_now) else $error("lock write not applied"); // [RULE20]

  property p_map;
    (dat_addr != mmp_pkg::SRAM_BASE || dat_sel.sram) && (eep_map_en || !dat_sel.eep)
      && (dat_addr != mmp_pkg::SRAM_END || (dat_sel.ext && !dat_sel.sram));
  endproperty
  a_map: assert property (p_map) else $error("data decode wrong"); // [RULE13] [RULE14] [RULE15]

  sequence s_gp_set;
    io_bit_req && io_bit_op == mmp_pkg::BIT_SET && io_addr < mmp_pkg::GP_LIMIT;
  endsequence
  property p_gp_bit;
    s_gp_set ##1 (io_bit_req && io_bit_op == mmp_pkg::BIT_TEST && $stable(io_addr) && $stable(io_bit))
      |=> io_bit_vld && io_bit_val;
  endproperty
  a_gp_bit: assert property (p_gp_bit) else $error("bit set lost"); // [RULE19]

  property p_bit_range;
    io_bit_req && io_addr > mmp_pkg::BIT_IO_LAST |-> io_bit_err && !io_bit_fwd;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op beyond range"); // [RULE17]

endmodule // mmp_policy

/* File: testbench/mmp_array_model.sv */
// flash array stand-in: answers a chip erase with a done pulse after a chosen delay
// assumes arr_erase_all is a one-cycle strobe and erase_dly is at least one
`timescale 1ns/10ps
module mmp_array_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // erase handshake
  input wire logic arr_erase_all,
  input wire logic [3:0] erase_dly,
  output logic arr_done
);
  logic [3:0] cnt_q;
  // ==========================================
  // erase timer, done only once the array is blank
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      arr_done <= 1'b0;
    end else begin
      arr_done <= (cnt_q == 4'h1);
      if (arr_erase_all) begin
        cnt_q <= erase_dly;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // mmp_array_model

/* File: testbench/mmp_policy_bench.sv */
// self-checking bench for the memory map and nonvolatile access policy
// assumes mmp_policy and mmp_array_model are compiled with mmp_pkg
`timescale 1ns/10ps
module mmp_policy_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [19:0] dat_addr = 20'h00000;
  logic dat_we = 1'b0;
  logic [7:0] dat_wdata = 8'h00;
  logic eep_map_en = 1'b0;
  logic io_bit_req = 1'b0;
  mmp_pkg::mmp_bitop_type io_bit_op = mmp_pkg::BIT_TEST;
  logic [5:0] io_addr = 6'h00;
  logic [2:0] io_bit = 3'h0;
  logic nvm_valid = 1'b0;
  mmp_pkg::mmp_req_type nvm_req = '0;
  logic [7:0] psig_cal = 8'h5C;
  logic [3:0] erase_dly = 4'h1;
  mmp_pkg::mmp_dsel_type dat_sel;
  mmp_pkg::mmp_op_type arr_op;
  logic [7:0] gp_rdata, lock_bits, fuse_bits, cal_value;
  logic io_bit_fwd, io_bit_err, io_bit_vld, io_bit_val, nvm_busy, nvm_ok, nvm_deny;
  logic arr_rd, arr_wr, arr_erase, arr_erase_all, arr_done, cal_load;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h00000040;
  logic [7:0] lock_exp = 8'hFF;
  logic [7:0] fuse_exp = 8'hFF;
  logic [19:0] corner [11] = '{20'h0000F, 20'h00010, 20'h00FFF, 20'h01000, 20'h017FF, 20'h01800,
                               20'h01FFF, 20'h02000, 20'h03FFF, 20'h04000, 20'hFFFFF};

  always #10 sys_clk = ~sys_clk;

  mmp_policy i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .dat_addr(dat_addr), .dat_we(dat_we),
    .dat_wdata(dat_wdata), .eep_map_en(eep_map_en), .dat_sel(dat_sel), .gp_rdata(gp_rdata),
    .io_bit_req(io_bit_req), .io_bit_op(io_bit_op), .io_addr(io_addr), .io_bit(io_bit),
    .io_bit_fwd(io_bit_fwd), .io_bit_err(io_bit_err), .io_bit_vld(io_bit_vld), .io_bit_val(io_bit_val),
    .nvm_valid(nvm_valid), .nvm_req(nvm_req), .nvm_busy(nvm_busy), .nvm_ok(nvm_ok), .nvm_deny(nvm_deny),
    .arr_rd(arr_rd), .arr_wr(arr_wr), .arr_erase(arr_erase), .arr_erase_all(arr_erase_all),
    .arr_op(arr_op), .arr_done(arr_done), .lock_bits(lock_bits), .fuse_bits(fuse_bits),
    .psig_cal(psig_cal), .cal_load(cal_load), .cal_value(cal_value));
  mmp_array_model i_array (.sys_clk(sys_clk), .sys_rst(sys_rst), .arr_erase_all(arr_erase_all),
    .erase_dly(erase_dly), .arr_done(arr_done));

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic mmp_pkg::mmp_dsel_type exp_sel(input logic [19:0] a, input logic m);
    mmp_pkg::mmp_dsel_type s;
    s.io = a < mmp_pkg::IO_LIMIT;
    s.gp = a < 20'h00010;
    s.eep = m && a >= 20'h01000 && a < mmp_pkg::EEP_END;
    s.sram = a >= 20'h02000 && a < mmp_pkg::SRAM_END;
    s.ext = a >= mmp_pkg::SRAM_END && a <= 20'hFFFFF;
    return s;
  endfunction

  function automatic logic exp_ok(input mmp_pkg::mmp_req_type r, input logic [7:0] lk);
    int sh;
    logic wr;
    sh = r.addr >= mmp_pkg::BOOT_BASE ? 4 : (r.addr >= mmp_pkg::BOOT_BASE - mmp_pkg::BOOT_WORDS ? 2 : 0);
    wr = lk[sh] && (r.prog || r.pc >= mmp_pkg::BOOT_BASE);
    if (r.cmd == mmp_pkg::CMD_CHIP) return r.prog;
    case (r.space)
      mmp_pkg::SP_FLASH: return r.cmd == mmp_pkg::CMD_READ ? lk[sh+1] : wr;
      mmp_pkg::SP_USIG: return 1'b1;
      mmp_pkg::SP_PSIG: return r.cmd == mmp_pkg::CMD_READ;
      mmp_pkg::SP_FUSE: return r.cmd == mmp_pkg::CMD_READ || (r.cmd == mmp_pkg::CMD_WRITE && r.prog);
      default: return r.cmd != mmp_pkg::CMD_ERASE;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic nvm_op(input int p, input mmp_pkg::mmp_cmd_type c, input mmp_pkg::mmp_space_type s,
                        input logic [16:0] a, input logic [16:0] pc, input logic [15:0] d);
    mmp_pkg::mmp_req_type r;
    logic ok;
    int n;
    r = '{prog: p[0], cmd: c, space: s, addr: a, pc: pc, data: d};
    ok = exp_ok(r, lock_exp);
    @(posedge sys_clk);
    nvm_valid <= 1'b1;
    nvm_req <= r;
    @(posedge sys_clk);
    nvm_valid <= 1'b0;
    #1;
    if (c == mmp_pkg::CMD_CHIP && ok) begin
      check("erase_all", arr_erase_all, 1);
      n = 0;
      while (nvm_ok !== 1'b1 && n < 40) begin
        check("lock_kept", lock_bits, lock_exp);
        check("busy", nvm_busy, 1);
        @(posedge sys_clk);
        #1;
        n++;
      end
      lock_exp = 8'hFF;
    end else begin
      check("deny", nvm_deny, !ok);
      if (s == mmp_pkg::SP_FLASH) begin
        check("arr_wr", arr_wr, ok && c == mmp_pkg::CMD_WRITE);
        check("arr_rd", arr_rd, ok && c == mmp_pkg::CMD_READ);
        check("arr_erase", arr_erase, ok && c == mmp_pkg::CMD_ERASE);
        if (ok) check("arr_addr", arr_op.addr, a);
      end
    end
    check("ok", nvm_ok, ok);
    if (ok && c == mmp_pkg::CMD_WRITE && s == mmp_pkg::SP_LOCK) lock_exp = lock_exp & d[7:0];
    if (ok && c == mmp_pkg::CMD_WRITE && s == mmp_pkg::SP_FUSE) fuse_exp = d[7:0];
    @(posedge sys_clk);
    #1;
    check("lock_bits", lock_bits, lock_exp);
    check("fuse_bits", fuse_bits, fuse_exp);
  endtask

  task automatic bit_op(input mmp_pkg::mmp_bitop_type op, input logic [5:0] a, input logic [2:0] b,
                        input logic ev);
    @(posedge sys_clk);
    io_bit_req <= 1'b1;
    io_bit_op <= op;
    io_addr <= a;
    io_bit <= b;
    #1;
    check("fwd", io_bit_fwd, a >= 6'h10 && a <= 6'h1F);
    check("err", io_bit_err, a > 6'h1F);
    @(posedge sys_clk);
    io_bit_req <= 1'b0;
    #1;
    check("vld", io_bit_vld, op == mmp_pkg::BIT_TEST && a < 6'h10);
    if (op == mmp_pkg::BIT_TEST && a < 6'h10) check("val", io_bit_val, ev);
  endtask

  task automatic gp_access(input logic we, input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    dat_addr <= {16'h0000, a};
    dat_we <= we;
    dat_wdata <= v;
    @(posedge sys_clk);
    dat_we <= 1'b0;
    #1;
    if (!we) check("gp_rdata", gp_rdata, v);
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] x;
    logic [7:0] v;
    logic [3:0] a;
    mmp_pkg::mmp_space_type s;
    mmp_pkg::mmp_cmd_type c;
    logic p;
    x = rnd();
    psig_cal <= x[7:0];
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("cal_load", cal_load, 1);
    check("cal_value", cal_value, psig_cal);
    check("lock_rst", lock_bits, 8'hFF);
    check("fuse_rst", fuse_bits, 8'hFF);
    check("busy_rst", nvm_busy, 0);
    for (int i = 0; i < 41; i++) begin
      x = rnd();
      @(posedge sys_clk);
      dat_addr <= i < 11 ? corner[i] : x[19:0];
      eep_map_en <= x[20];
      #1;
      check("dat_sel", dat_sel, exp_sel(dat_addr, eep_map_en));
    end
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      a = x[3:0];
      v = x[11:4] & ~(8'h01 << x[14:12]);
      gp_access(1'b1, a, v);
      bit_op(mmp_pkg::BIT_SET, {2'b00, a}, x[14:12], 1'b0);
      bit_op(mmp_pkg::BIT_TEST, {2'b00, a}, x[14:12], 1'b1);
      gp_access(1'b0, a, v | (8'h01 << x[14:12]));
      bit_op(mmp_pkg::BIT_CLR, {2'b00, a}, x[14:12], 1'b0);
      bit_op(mmp_pkg::BIT_TEST, {2'b00, a}, x[14:12], 1'b0);
      gp_access(1'b0, a, v);
      @(posedge sys_clk);
      io_bit_req <= 1'b1;
      io_bit_op <= mmp_pkg::BIT_SET;
      io_addr <= {2'b00, a};
      io_bit <= x[14:12];
      @(posedge sys_clk);
      io_bit_op <= mmp_pkg::BIT_TEST;
      @(posedge sys_clk);
      io_bit_req <= 1'b0;
      #1;
      check("b2b_vld", io_bit_vld, 1);
      check("b2b_val", io_bit_val, 1);
      bit_op(mmp_pkg::BIT_SET, x[21:16], x[14:12], 1'b0);
    end
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FLASH, 17'h00100, 17'h00200, 16'h1234);
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FLASH, 17'h10010, 17'h10000, 16'hA55A);
    nvm_op(1, mmp_pkg::CMD_READ, mmp_pkg::SP_FLASH, 17'h10010, 17'h00000, 16'h0000);
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_PSIG, 17'h00004, 17'h10000, 16'h00AA);
    nvm_op(1, mmp_pkg::CMD_ERASE, mmp_pkg::SP_PSIG, 17'h00000, 17'h00000, 16'h0000);
    nvm_op(0, mmp_pkg::CMD_READ, mmp_pkg::SP_PSIG, 17'h00004, 17'h00000, 16'h0000);
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FUSE, 17'h00000, 17'h10000, 16'h0000);
    nvm_op(1, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FUSE, 17'h00000, 17'h00000, 16'h007E);
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_USIG, 17'h00008, 17'h00000, 16'hBEEF);
    nvm_op(1, mmp_pkg::CMD_ERASE, mmp_pkg::SP_USIG, 17'h00000, 17'h00000, 16'h0000);
    nvm_op(0, mmp_pkg::CMD_WRITE, mmp_pkg::SP_LOCK, 17'h00000, 17'h00000, 16'h00FE);
    nvm_op(1, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FLASH, 17'h0EFFF, 17'h00000, 16'h0001);
    nvm_op(1, mmp_pkg::CMD_WRITE, mmp_pkg::SP_FLASH, 17'h0F000, 17'h00000, 16'h0002);
    nvm_op(1, mmp_pkg::CMD_WRITE, mmp_pkg::SP_LOCK, 17'h00000, 17'h00000, 16'h00FF);
    nvm_op(0, mmp_pkg::CMD_CHIP, mmp_pkg::SP_FLASH, 17'h00000, 17'h10000, 16'h0000);
    nvm_op(1, mmp_pkg::CMD_CHIP, mmp_pkg::SP_FLASH, 17'h00000, 17'h00000, 16'h0000);
    erase_dly <= 4'h9;
    for (int i = 0; i < 80; i++) begin
      if (i == 40) nvm_op(1, mmp_pkg::CMD_CHIP, mmp_pkg::SP_FLASH, 17'h00000, 17'h00000, 16'h0000);
      x = rnd();
      s = x[7:5] > 3'h4 ? mmp_pkg::SP_FLASH : mmp_pkg::mmp_space_type'(x[7:5]);
      c = x[9:8] == 2'h3 ? mmp_pkg::CMD_READ : mmp_pkg::mmp_cmd_type'(x[9:8]);
      p = x[10] && !(s == mmp_pkg::SP_FUSE && c == mmp_pkg::CMD_WRITE);
      if (s == mmp_pkg::SP_LOCK && c == mmp_pkg::CMD_ERASE) c = mmp_pkg::CMD_READ;
      nvm_op(p, c, s, x[1] ? {1'b1, x[27:12]} : {x[0] ? 5'h0F : 5'h00, x[23:12]},
             {x[11], x[31:16]}, {x[31:24], x[23:16] | x[15:8] | x[31:24]});
    end
    wrap_up();
  end

  // ==========================================
  // watchdog
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
endmodule // mmp_policy_bench
